// [src/idrsp_regs.svh]
// Word indices, field positions and fixed values of the identify parameter record.
// Assumes inclusion by the identify responder sources only.
`ifndef IDRSP_REGS_SVH
`define IDRSP_REGS_SVH

`define IDRSP_REC_WORDS     9'h100
`define IDRSP_W_CONFIG      8'h00
`define IDRSP_W_LCYL        8'h01
`define IDRSP_W_LHEAD       8'h03
`define IDRSP_W_LSECT       8'h06
`define IDRSP_W_SERIAL_LO   8'h0A
`define IDRSP_W_SERIAL_HI   8'h13
`define IDRSP_W_FW_LO       8'h17
`define IDRSP_W_FW_HI       8'h1A
`define IDRSP_W_MODEL_LO    8'h1B
`define IDRSP_W_MODEL_HI    8'h2E
`define IDRSP_W_MULT_MAX    8'h2F
`define IDRSP_W_CAPS        8'h31
`define IDRSP_W_VALID       8'h35
`define IDRSP_W_CUR_CYL     8'h36
`define IDRSP_W_CUR_HEAD    8'h37
`define IDRSP_W_CUR_SECT    8'h38
`define IDRSP_W_CUR_CAP_LO  8'h39
`define IDRSP_W_CUR_CAP_HI  8'h3A
`define IDRSP_W_MULT_CUR    8'h3B
`define IDRSP_W_LBA_LO      8'h3C
`define IDRSP_W_LBA_HI      8'h3D
`define IDRSP_W_MDMA        8'h3F
`define IDRSP_W_PIO         8'h40
`define IDRSP_W_MDMA_MIN    8'h41
`define IDRSP_W_MDMA_REC    8'h42
`define IDRSP_W_PIO_MIN     8'h43
`define IDRSP_W_PIO_IORDY   8'h44
`define IDRSP_W_QUEUE       8'h4B
`define IDRSP_W_MAJOR       8'h50
`define IDRSP_W_MINOR       8'h51
`define IDRSP_W_CMDSET      8'h52
`define IDRSP_W_UDMA        8'h58

`define IDRSP_CAPS_FIXED    16'h0300
`define IDRSP_CMDSET_MASK   16'h7FEF
`define IDRSP_MAJOR_MASK    16'h003C

`endif

// [src/idrsp_pkg.sv]
// Types shared by the identify responder.
// Assumes the constants header is compiled alongside.
package idrsp_pkg;

  typedef logic [15:0] idrsp_word_t;

  typedef enum logic [1:0] {
    IDRSP_IDLE = 2'b00,
    IDRSP_FILL = 2'b01,
    IDRSP_DRAIN = 2'b10,
    IDRSP_IRQ = 2'b11
  } idrsp_state_t;

endpackage : idrsp_pkg

// [src/idrsp_skid.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module idrsp_skid #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_count  = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : idrsp_skid

// [src/idrsp_top.sv]
// Identify responder: builds the 256-word parameter record and streams it to the host.
// Assumes drive state arrives as stable same-clock ports and the host reads via a handshake.
//
// What this block does
// - On command: busy, fill record, raise data request, then pulse interrupt.
// - Reserved bits and reserved words return zero.
// - Word 0 gives packet type, removable, fixed controller, incomplete bits.
// - Words 1, 3, 6 give logical cylinders, heads, sectors per track.
// - Words 10-19 serial, 23-26 firmware, 27-46 model, ASCII.
// - Word 47 gives the largest multiple-sector count per interrupt.
// - Word 49 gives standby timer, IORDY flags; bits 9-8 are one.
// - Word 53 bits 2-0 validate words 88, 64-70, 54-58.
// - Words 54-56 current geometry, 57-58 current capacity.
// - Word 59 gives multiple setting valid flag and current setting.
// - Words 60-61 give total user-addressable sectors.
// - Word 63 gives selected and supported multi-word DMA modes.
// - Word 64 low byte lists advanced PIO modes supported.
// - Words 65-68 hold DMA and PIO cycle times in nanoseconds.
// - Word 75 low five bits hold maximum queue depth minus one.
// - Word 80 flags major versions 5 to 2; word 81 minor version.
// - Word 82 flags supported command sets; bit 4 is zero.
// - All-zero or all-one words 82 and 83 mean notification unsupported.
// - Word 88 gives selected and supported ultra DMA modes.
`timescale 1ns/1ps
`include "idrsp_regs.svh"
module idrsp_top (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Command strobe from the command decoder.
  input  wire logic                  cmd_start,
  // Drive identity and geometry.
  input  wire logic                  is_packet,
  input  wire logic                  removable,
  input  wire logic                  fixed_ctrl,
  input  wire logic                  resp_incomplete,
  input  wire logic [15:0]           log_cyl,
  input  wire logic [15:0]           log_head,
  input  wire logic [15:0]           log_sect,
  input  wire logic [159:0]          serial_str,
  input  wire logic [63:0]           fw_str,
  input  wire logic [319:0]          model_str,
  input  wire logic [7:0]            mult_max,
  // Capabilities.
  input  wire logic                  std_standby,
  input  wire logic                  iordy_sup,
  input  wire logic                  iordy_dis,
  input  wire logic [2:0]            field_valid,
  input  wire logic [15:0]           cur_cyl,
  input  wire logic [15:0]           cur_head,
  input  wire logic [15:0]           cur_sect,
  input  wire logic [31:0]           cur_cap,
  input  wire logic                  mult_valid,
  input  wire logic [7:0]            mult_cur,
  input  wire logic [31:0]           lba_total,
  input  wire logic [2:0]            mdma_sel,
  input  wire logic [2:0]            mdma_sup,
  input  wire logic [7:0]            pio_sup,
  input  wire logic [15:0]           mdma_min_ns,
  input  wire logic [15:0]           mdma_rec_ns,
  input  wire logic [15:0]           pio_min_ns,
  input  wire logic [15:0]           pio_iordy_ns,
  input  wire logic [4:0]            queue_depth_m1,
  input  wire logic [15:0]           major_ver,
  input  wire logic [15:0]           minor_ver,
  input  wire logic [15:0]           cmdset_sup,
  input  wire logic [5:0]            udma_sel,
  input  wire logic [5:0]            udma_sup,
  // Status toward the host register file.
  output logic                       busy,
  output logic                       data_req,
  output logic                       irq_pulse,
  // Record read port toward the host.
  output logic                       rd_valid,
  input  wire logic                  rd_ready,
  output idrsp_pkg::idrsp_word_t     rd_data
);
  import idrsp_pkg::*;

  // ---------------------------------------------------------------
  // Record word builder
  // ---------------------------------------------------------------
  // Strings are packed first character in the top byte of the vector,
  // and each word carries two characters, first in the high byte.
  function automatic idrsp_word_t str_word(input logic [319:0] s, input logic [7:0] i);
    return s[319 - 16 * i -: 16];
  endfunction : str_word

  // Keeps only the highest requested bit so two selected modes never show.
  function automatic logic [2:0] one_hot3(input logic [2:0] v);
    return v[2] ? 3'h4 : (v[1] ? 3'h2 : (v[0] ? 3'h1 : 3'h0));
  endfunction : one_hot3

  function automatic idrsp_word_t rec_word(input logic [7:0] idx);
    idrsp_word_t w;
    w = 16'h0000;
    if (idx == `IDRSP_W_CONFIG) begin
      w = {is_packet, 7'h00, removable, fixed_ctrl, 3'h0, resp_incomplete, 2'h0};
    end else if (idx == `IDRSP_W_LCYL) begin
      w = log_cyl;
    end else if (idx == `IDRSP_W_LHEAD) begin
      w = log_head;
    end else if (idx == `IDRSP_W_LSECT) begin
      w = log_sect;
    end else if (idx >= `IDRSP_W_SERIAL_LO && idx <= `IDRSP_W_SERIAL_HI) begin
      w = str_word({serial_str, 160'h0}, idx - `IDRSP_W_SERIAL_LO);
    end else if (idx >= `IDRSP_W_FW_LO && idx <= `IDRSP_W_FW_HI) begin
      w = str_word({fw_str, 256'h0}, idx - `IDRSP_W_FW_LO);
    end else if (idx >= `IDRSP_W_MODEL_LO && idx <= `IDRSP_W_MODEL_HI) begin
      w = str_word(model_str, idx - `IDRSP_W_MODEL_LO);
    end else if (idx == `IDRSP_W_MULT_MAX) begin
      w = {8'h00, mult_max};
    end else if (idx == `IDRSP_W_CAPS) begin
      w = `IDRSP_CAPS_FIXED | {2'h0, std_standby, 1'b0, iordy_sup, iordy_dis, 10'h000};
    end else if (idx == `IDRSP_W_VALID) begin
      w = {13'h0000, field_valid};
    end else if (idx == `IDRSP_W_CUR_CYL) begin
      w = cur_cyl;
    end else if (idx == `IDRSP_W_CUR_HEAD) begin
      w = cur_head;
    end else if (idx == `IDRSP_W_CUR_SECT) begin
      w = cur_sect;
    end else if (idx == `IDRSP_W_CUR_CAP_LO) begin
      w = cur_cap[15:0];
    end else if (idx == `IDRSP_W_CUR_CAP_HI) begin
      w = cur_cap[31:16];
    end else if (idx == `IDRSP_W_MULT_CUR) begin
      w = {7'h00, mult_valid, mult_cur};
    end else if (idx == `IDRSP_W_LBA_LO) begin
      w = lba_total[15:0];
    end else if (idx == `IDRSP_W_LBA_HI) begin
      w = lba_total[31:16];
    end else if (idx == `IDRSP_W_MDMA) begin
      w = {5'h00, one_hot3(mdma_sel), 5'h00, mdma_sup};
    end else if (idx == `IDRSP_W_PIO) begin
      w = {8'h00, pio_sup};
    end else if (idx == `IDRSP_W_MDMA_MIN) begin
      w = mdma_min_ns;
    end else if (idx == `IDRSP_W_MDMA_REC) begin
      w = mdma_rec_ns;
    end else if (idx == `IDRSP_W_PIO_MIN) begin
      w = pio_min_ns;
    end else if (idx == `IDRSP_W_PIO_IORDY) begin
      w = pio_iordy_ns;
    end else if (idx == `IDRSP_W_QUEUE) begin
      w = {11'h000, queue_depth_m1};
    end else if (idx == `IDRSP_W_MAJOR) begin
      w = major_ver & `IDRSP_MAJOR_MASK;
    end else if (idx == `IDRSP_W_MINOR) begin
      w = minor_ver;
    end else if (idx == `IDRSP_W_CMDSET) begin
      // Bit 15 is cleared by the mask, so this word can never read all ones,
      // and an input with no bits set other than 15 and 4 is the only way to report no notification.
      w = cmdset_sup & `IDRSP_CMDSET_MASK;
    end else if (idx == `IDRSP_W_UDMA) begin
      w = {2'h0, udma_sel, 2'h0, udma_sup};
    end
    return w;
  endfunction : rec_word

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  idrsp_state_t state;
  idrsp_state_t next_state;
  logic [8:0]   fill_idx;
  logic [8:0]   next_fill_idx;
  logic [8:0]   read_cnt;
  logic [8:0]   next_read_cnt;
  logic         next_busy;
  logic         next_data_req;
  logic         next_irq_pulse;
  idrsp_word_t  buf_mem [256];
  logic         buf_wr;
  logic         fill_valid;
  logic         fill_ready;
  logic         rd_take;

  assign buf_wr  = (state == IDRSP_FILL);
  assign rd_take = rd_valid && rd_ready;

  always_comb begin
    next_state     = state;
    next_fill_idx  = fill_idx;
    next_read_cnt  = read_cnt;
    next_busy      = busy;
    next_data_req  = data_req;
    next_irq_pulse = 1'b0;
    fill_valid     = 1'b0;
    unique case (state)
      IDRSP_IDLE: begin
        if (cmd_start) begin
          next_busy     = 1'b1;
          next_fill_idx = 9'h000;
          next_state    = IDRSP_FILL;
        end
      end
      IDRSP_FILL: begin
        next_fill_idx = fill_idx + 9'h001;
        if (fill_idx == `IDRSP_REC_WORDS - 9'h001) begin
          next_fill_idx = 9'h000;
          next_read_cnt = 9'h000;
          next_data_req = 1'b1;
          next_busy     = 1'b0;
          next_state    = IDRSP_IRQ;
        end
      end
      IDRSP_IRQ: begin
        next_irq_pulse = 1'b1;
        next_state     = IDRSP_DRAIN;
      end
      IDRSP_DRAIN: begin
        // The host reads word by word through the buffer below.
        fill_valid = (fill_idx < `IDRSP_REC_WORDS);
        if (fill_valid && fill_ready) begin
          next_fill_idx = fill_idx + 9'h001;
        end
        if (rd_take) begin
          next_read_cnt = read_cnt + 9'h001;
          if (read_cnt == `IDRSP_REC_WORDS - 9'h001) begin
            next_data_req = 1'b0;
            next_state    = IDRSP_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= IDRSP_IDLE;
      fill_idx  <= 9'h000;
      read_cnt  <= 9'h000;
      busy      <= 1'b0;
      data_req  <= 1'b0;
      irq_pulse <= 1'b0;
    end else begin
      state     <= next_state;
      fill_idx  <= next_fill_idx;
      read_cnt  <= next_read_cnt;
      busy      <= next_busy;
      data_req  <= next_data_req;
      irq_pulse <= next_irq_pulse;
    end
  end

  // Snapshot so the record stays coherent while the drive state changes.
  always_ff @(posedge clk) begin
    if (buf_wr) begin
      buf_mem[fill_idx[7:0]] <= rec_word(fill_idx[7:0]);
    end
  end

  // ---------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------
  // A host stall holds a word here rather than losing it.
  idrsp_skid #(
    .WIDTH (16)
  ) u_skid (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (buf_mem[fill_idx[7:0]]),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

endmodule : idrsp_top

// [tb/idrsp_assertions.sv]
// Checker for the identify responder, bound to its top module.
// Assumes one clock and the synchronous active-high reset of the top module.
`timescale 1ns/1ps
module idrsp_assertions (
  // Clock and reset.
  input wire logic                   clk,
  input wire logic                   rst,
  // Command and status.
  input wire logic                   cmd_start,
  input wire logic                   busy,
  input wire logic                   data_req,
  input wire logic                   irq_pulse,
  // Record read port.
  input wire logic                   rd_valid,
  input wire logic                   rd_ready,
  input wire idrsp_pkg::idrsp_word_t rd_data
);
  import idrsp_pkg::*;
  logic [8:0] fill_cnt;
  logic [8:0] next_fill_cnt;
  logic [8:0] word_cnt;
  logic [8:0] next_word_cnt;
  // Fill length and words taken are counted here so long spans stay cheap to check.
  always_comb begin
    next_fill_cnt = busy ? fill_cnt + 9'h001 : 9'h000;
    next_word_cnt = busy ? 9'h000 : word_cnt + {8'h00, rd_valid && rd_ready};
  end
  always_ff @(posedge clk) begin
    fill_cnt <= rst ? 9'h000 : next_fill_cnt;
    word_cnt <= rst ? 9'h000 : next_word_cnt;
  end
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_cmd_busy: assert property (cmd_start && !busy && !data_req |=> busy)
    else $error("command in idle did not raise busy");
  chk_cmd_refused: assert property (cmd_start && data_req |=> !busy)
    else $error("command taken while record pending");
  chk_fill_len: assert property ($fell(busy) && !$past(rst) |-> fill_cnt == 9'h100)
    else $error("fill did not last 256 cycles");
  chk_fill_order: assert property ($fell(busy) && !$past(rst) |->
    data_req && !irq_pulse ##1 irq_pulse)
    else $error("data request and interrupt out of order");
  chk_irq_pulse: assert property (irq_pulse |-> data_req && $past(data_req) ##1 !irq_pulse)
    else $error("interrupt not a single pulse after data request");
  chk_busy_drq: assert property (!(busy && data_req))
    else $error("busy and data request together");
  chk_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read word dropped while stalled");
  chk_valid_drq: assert property (rd_valid |-> data_req)
    else $error("word offered without data request");
  chk_drq_words: assert property ($fell(data_req) && !$past(rst) |->
    word_cnt == 9'h100 && $past(rd_valid && rd_ready))
    else $error("data request fell before 256 words");
  chk_mdma_onehot: assert property (rd_valid && word_cnt == 9'h03F |->
    $onehot0(rd_data[10:8]))
    else $error("more than one multi-word DMA mode shown as selected");
  chk_caps_ones: assert property (rd_valid && word_cnt == 9'h031 |->
    rd_data[9:8] == 2'h3)
    else $error("capabilities word bits 9 and 8 not both one");
  chk_cmdset_rsvd: assert property (rd_valid && word_cnt == 9'h052 |->
    !rd_data[15] && !rd_data[4])
    else $error("command set word shows a bit that must read zero");
  cov_fill: cover property ($rose(busy));
  cov_stall: cover property (rd_valid && !rd_ready);
  cov_done: cover property ($fell(data_req));
endmodule : idrsp_assertions

bind idrsp_top idrsp_assertions idrsp_assertions_i (.clk, .rst, .cmd_start, .busy, .data_req,
  .irq_pulse, .rd_valid, .rd_ready, .rd_data);

// [tb/idrsp_host.sv]
// Host reader model: waits for the interrupt, then takes the record word by word.
// Assumes the bench watches the handshake itself; slow asks for random stalls.
`timescale 1ns/1ps
module idrsp_host (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Device status and read accept.
  input  wire logic data_req,
  input  wire logic irq_pulse,
  input  wire logic slow,
  output logic      rd_ready
);
  logic armed;
  // Reset is high at the first edges, so armed and the accept start low without an initial block.
  always @(posedge clk) begin
    if (rst || !data_req) armed <= 1'b0;
    else if (irq_pulse) armed <= 1'b1;
  end
  always @(negedge clk) rd_ready <= armed && (!slow || ($urandom % 3 == 0));
endmodule : idrsp_host

// [tb/tb.sv]
// Bench: random drive state, each record word compared with a model built here.
// Assumes the responder, the host model and the checker are compiled first.
`timescale 1ns/1ps
module tb;
  import idrsp_pkg::*;
  logic clk, rst, cmd_start, slow, busy, data_req, irq_pulse, rd_valid, rd_ready;
  logic is_packet, removable, fixed_ctrl, resp_incomplete, std_standby, iordy_sup;
  logic iordy_dis, mult_valid;
  logic [2:0] field_valid, mdma_sel, mdma_sup;
  logic [4:0] queue_depth_m1;
  logic [5:0] udma_sel, udma_sup;
  logic [7:0] mult_max, mult_cur, pio_sup;
  logic [15:0] log_cyl, log_head, log_sect, cur_cyl, cur_head, cur_sect, mdma_min_ns;
  logic [15:0] mdma_rec_ns, pio_min_ns, pio_iordy_ns, major_ver, minor_ver, cmdset_sup;
  logic [31:0] cur_cap, lba_total;
  logic [63:0] fw_str;
  logic [159:0] serial_str;
  logic [319:0] model_str;
  logic [895:0] rnd;
  idrsp_word_t rd_data;
  idrsp_word_t ex [256];
  int error_cnt, tests_run;
  idrsp_top idrsp_top_i (
    .clk, .rst, .cmd_start, .is_packet, .removable, .fixed_ctrl, .resp_incomplete,
    .log_cyl, .log_head, .log_sect, .serial_str, .fw_str, .model_str, .mult_max,
    .std_standby, .iordy_sup, .iordy_dis, .field_valid, .cur_cyl, .cur_head, .cur_sect,
    .cur_cap, .mult_valid, .mult_cur, .lba_total, .mdma_sel, .mdma_sup, .pio_sup,
    .mdma_min_ns, .mdma_rec_ns, .pio_min_ns, .pio_iordy_ns, .queue_depth_m1, .major_ver,
    .minor_ver, .cmdset_sup, .udma_sel, .udma_sup, .busy, .data_req, .irq_pulse,
    .rd_valid, .rd_ready, .rd_data
  );
  idrsp_host idrsp_host_i (.clk, .rst, .data_req, .irq_pulse, .slow, .rd_ready);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string name, input idrsp_word_t seen, input idrsp_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic wait_limit();
    chk("wait limit", 16'h0000, 16'h0001);
    end_of_test();
  endtask : wait_limit
  // Status nibble: busy, data request, interrupt, word offered.
  function automatic idrsp_word_t st();
    return {12'h000, busy, data_req, irq_pulse, rd_valid};
  endfunction : st
  task automatic rand_in();
    for (int i = 0; i < 28; i++) rnd[32*i +: 32] = $urandom;
    {is_packet, removable, fixed_ctrl, resp_incomplete, std_standby, iordy_sup, iordy_dis,
     mult_valid, field_valid, mdma_sel, mdma_sup, queue_depth_m1, udma_sel, udma_sup,
     mult_max, mult_cur, pio_sup, log_cyl, log_head, log_sect, cur_cyl, cur_head, cur_sect,
     mdma_min_ns, mdma_rec_ns, pio_min_ns, pio_iordy_ns, major_ver, minor_ver, cmdset_sup,
     cur_cap, lba_total, fw_str, serial_str, model_str} = rnd[873:0];
  endtask : rand_in
  task automatic set_exp();
    foreach (ex[i]) ex[i] = 16'h0000;
    ex[0] = {is_packet, 7'h00, removable, fixed_ctrl, 3'h0, resp_incomplete, 2'h0};
    ex[1] = log_cyl;
    ex[3] = log_head;
    ex[6] = log_sect;
    for (int i = 0; i < 20; i++) begin
      ex[27+i] = model_str[319-16*i -: 16];
      if (i < 10) ex[10+i] = serial_str[159-16*i -: 16];
      if (i < 4) ex[23+i] = fw_str[63-16*i -: 16];
    end
    ex[47] = {8'h00, mult_max};
    ex[49] = {2'h0, std_standby, 1'b0, iordy_sup, iordy_dis, 2'h3, 8'h00};
    ex[53] = {13'h0000, field_valid};
    ex[54] = cur_cyl;
    ex[55] = cur_head;
    ex[56] = cur_sect;
    ex[57] = cur_cap[15:0];
    ex[58] = cur_cap[31:16];
    ex[59] = {7'h00, mult_valid, mult_cur};
    ex[60] = lba_total[15:0];
    ex[61] = lba_total[31:16];
    ex[63] = {5'h00, mdma_sel[2] ? 3'h4 : (mdma_sel[1] ? 3'h2 : {2'h0, mdma_sel[0]}),
              5'h00, mdma_sup};
    ex[64] = {8'h00, pio_sup};
    ex[65] = mdma_min_ns;
    ex[66] = mdma_rec_ns;
    ex[67] = pio_min_ns;
    ex[68] = pio_iordy_ns;
    ex[75] = {11'h000, queue_depth_m1};
    ex[80] = major_ver & 16'h003C;
    ex[81] = minor_ver;
    ex[82] = cmdset_sup & 16'h7FEF;
    ex[88] = {2'h0, udma_sel, 2'h0, udma_sup};
  endtask : set_exp
  // Entered and left at a falling edge; poke repeats the command while it must be ignored.
  task automatic one_rec(input bit poke);
    int n;
    int idx;
    set_exp();
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    chk("status", st(), 16'h0008);
    n = 0;
    while (busy && n < 400) begin
      @(negedge clk);
      n++;
      cmd_start = poke && n == 10;
    end
    if (n == 400) wait_limit();
    chk("fill cycles", 16'(n), 16'h0100);
    chk("status", st(), 16'h0004);
    @(negedge clk);
    chk("status", st(), 16'h0006);
    idx = 0;
    n = 0;
    // Look just after the falling edge, once the host has settled its accept,
    // so the values seen are those that the next rising edge takes.
    while (idx < 256 && n < 5000) begin
      cmd_start = poke && idx == 50;
      #1;
      if (rd_valid && rd_ready) begin
        chk("record word", rd_data, ex[idx]);
        idx++;
      end
      @(negedge clk);
      n++;
    end
    if (n == 5000) wait_limit();
    chk("status", st(), 16'h0000);
  endtask : one_rec
  initial begin
    void'($urandom(32'h5bc0));
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    cmd_start = 1'b0;
    slow = 1'b0;
    rand_in();
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int r = 0; r < 4; r++) begin
      rand_in();
      if (r == 0) cmdset_sup = 16'hFFFF;
      if (r == 1) cmdset_sup = 16'h0000;
      if (r == 3) mdma_sel = 3'h3;
      slow = r[0];
      one_rec(r == 2);
    end
    slow = 1'b0;
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    repeat (400) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk("status", st(), 16'h0000);
    rst = 1'b0;
    one_rec(1'b0);
    end_of_test();
  end
endmodule : tb
